/* File: mrs_map.svh */
// Register offsets, reset values, codes and timing figures of the reset
// source controller. Assumes a 100 MHz system clock and 12-bit APB addresses.
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH

// Register byte offsets
`define MRS_OFS_VSEL      12'h000
`define MRS_OFS_CTRL      12'h004
`define MRS_OFS_WATCHDOG_CONTROL_REGISTER      12'h008
`define MRS_OFS_STAT      12'h00C

// Reset values
`define MRS_VSEL_POR      8'h55
`define MRS_WATCHDOG_CONTROL_REGISTER_POR      8'h53
`define MRS_PORT_INIT     8'hFF

// Threshold select codes, lowest to highest
`define MRS_VSEL_LV0      8'h55
`define MRS_VSEL_LV1      8'h33
`define MRS_VSEL_LV2      8'h99
`define MRS_VSEL_LV3      8'hAA

// Watchdog control upper field codes
`define MRS_WATCHDOG_CONTROL_REGISTER_DIS      5'h15
`define MRS_WATCHDOG_CONTROL_REGISTER_ENA      5'h0A

// Field positions
`define MRS_CTRL_KEEP     7
`define MRS_CTRL_LV       2
`define MRS_CTRL_VSEL     1
`define MRS_CTRL_WATCHDOG_CONTROL_REGISTER     0
`define MRS_STAT_TO       1
`define MRS_STAT_PD       0
`define MRS_WATCHDOG_CONTROL_REGISTER_EN_HI    7
`define MRS_WATCHDOG_CONTROL_REGISTER_EN_LO    3
`define MRS_WATCHDOG_CONTROL_REGISTER_WS_HI    2

// Timing
`define MRS_CLK_NS        10
`define MRS_POD_NS        50000000
`define MRS_UVQ_NS        120000
`define MRS_ACT_TICKS     2'h3
`define MRS_SST_FAST_INTERNAL_OSCILLATOR      24'h00_0010
`define MRS_SST_HXT       24'h00_0400
`define MRS_SST_SLOW_INTERNAL_OSCILLATOR      24'h00_0002

`endif

/* File: mrs_pkg.sv */
// Types shared by the reset source controller files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mrs_pkg;

  typedef enum logic [4:0] {
    MRS_ST_POR    = 5'h01,
    MRS_ST_RUN    = 5'h02,
    MRS_ST_ARM    = 5'h04,
    MRS_ST_HOLD   = 5'h08,
    MRS_ST_SETTLE = 5'h10
  } mrs_state_t;

  typedef enum logic [1:0] {
    MRS_OSC_FAST_INTERNAL_OSCILLATOR = 2'h0,
    MRS_OSC_HXT  = 2'h1,
    MRS_OSC_SLOW_INTERNAL_OSCILLATOR = 2'h2
  } mrs_osc_t;

  typedef struct packed {
    logic idle_clock_keep;
    logic low_voltage_flag;
    logic voltage_select_invalid_flag;
    logic watchdog_ctrl_invalid_flag;
  } mrs_flags_t;

  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
  } mrs_status_t;

endpackage : mrs_pkg

`default_nettype wire

/* File: mrs_sync.sv */
// Two-stage synchroniser for inputs arriving from outside clk_sys.
// Assumes the inputs are levels that stay stable for several cycles.
`default_nettype none

module mrs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_q[gi]   <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          meta_q[gi]   <= async_in[gi];
          sync_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : mrs_sync

`default_nettype wire

/* File: mrs_ctrl.sv */
// Reset source controller: merges power-on, under-voltage, watchdog and
// invalid-code resets into one internal reset, keeps the cause flags.
// Assumes resetn is the power-on reset, an APB master on clk_sys, and a
// watchdog counter and core on clk_sys; detector and slow oscillator are pins.
//
// Function
// - Power-on reset clears the program counter to zero.
// - Power-on reset presets all port data and direction bits to ones.
// - Internal reset held a power-on delay, typically 50 ms.
// - Qualified under-voltage resets the device and sets the low-voltage flag.
// - Under-voltage shorter than the qualify time is ignored.
// - Only four threshold select codes are valid.
// - Invalid select code resets after 2-3 slow ticks, restores its value.
// - Invalid select code sets the select-invalid flag.
// - Genuine under-voltage reset after 2-3 slow ticks keeps select value.
// - Under-voltage reset is disabled while powered down.
// - Threshold select register powers up as 0x55.
// - Hardware only sets the cause flags; software clears them.
// - Control flags bits 6 to 3 read zero.
// - Normal watchdog time-out acts like power-on, plus timeout flag.
// - Sleep watchdog time-out clears only PC and stack, sets timeout.
// - Wake settle time depends on the selected oscillator.
// - Watchdog control upper field other than 10101 or 01010 resets.
// - Such a reset sets the watchdog-control-invalid flag.
// - Power-on reset is automatic and sets no cause flag.
// - Power-on clears timeout and power-down flags; sleep time-out sets both.
// - Watchdog control register resets to 0x53 on full resets other than under-voltage resets.
//
// The implementer's own choices: the register addresses and register access over APB.
`default_nettype none
`include "mrs_map.svh"

module mrs_ctrl #(
  parameter logic [23:0] POD_CYC  = 24'(`MRS_POD_NS / `MRS_CLK_NS),
  parameter logic [23:0] QUAL_CYC = 24'(`MRS_UVQ_NS / `MRS_CLK_NS)
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Pins from outside the clock domain
  input  wire logic             under_voltage,
  input  wire logic             slow_internal_oscillator,
  // Core and watchdog side, same clock
  input  wire logic             wdt_timeout,
  input  wire logic             sleep_mode,
  input  wire logic             idle_mode,
  input  wire mrs_pkg::mrs_osc_t osc_sel,
  // Reset outputs
  output logic                  core_reset_n,
  output logic                  pc_sp_clear,
  output logic                  port_preset,
  output logic      [7:0]       port_init_value,
  output logic                  watchdog_enable,
  output logic      [2:0]       watchdog_period,
  output logic                  idle_clock_keep,
  output mrs_pkg::mrs_status_t  status
);

  mrs_pkg::mrs_state_t  state_q;
  mrs_pkg::mrs_flags_t  flags_q;
  mrs_pkg::mrs_status_t stat_q;
  logic [7:0]  vsel_q;
  logic [7:0]  watchdog_control_register_q;
  logic [23:0] cnt_q;
  logic [23:0] lvq_q;
  logic [1:0]  tick_q;
  logic        wake_q;
  logic        cause_lvd_q;
  logic        slow_internal_oscillator_prev_q;
  logic [31:0] prdata_q;
  logic [7:0]  port_q;

  logic [1:0]  sync_s;
  logic        uv_s;
  logic        slow_internal_oscillator_s;
  logic        slow_internal_oscillator_tick;
  logic        vsel_bad;
  logic        watchdog_control_register_bad;
  logic        lvd_hit;
  logic        full_req;
  logic        wake_req;
  logic        activate;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [23:0] settle_cyc;

  // Both pins pass two flip-flops before use
  mrs_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({under_voltage, slow_internal_oscillator}),
    .sync_out (sync_s)
  );

  assign uv_s   = sync_s[1];
  assign slow_internal_oscillator_s = sync_s[0];

  // Slow oscillator rising edge marks one slow tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slow_internal_oscillator_prev_q <= 1'b0;
    end else begin
      slow_internal_oscillator_prev_q <= slow_internal_oscillator_s;
    end
  end

  assign slow_internal_oscillator_tick = slow_internal_oscillator_s & ~slow_internal_oscillator_prev_q;

  // Code checks
  always_comb begin
    vsel_bad = 1'b1;
    unique case (vsel_q)
      `MRS_VSEL_LV0,
      `MRS_VSEL_LV1,
      `MRS_VSEL_LV2,
      `MRS_VSEL_LV3: vsel_bad = 1'b0;
      default:       vsel_bad = 1'b1;
    endcase
  end

  assign watchdog_control_register_bad =
    (watchdog_control_register_q[`MRS_WATCHDOG_CONTROL_REGISTER_EN_HI:`MRS_WATCHDOG_CONTROL_REGISTER_EN_LO] != `MRS_WATCHDOG_CONTROL_REGISTER_DIS) &&
    (watchdog_control_register_q[`MRS_WATCHDOG_CONTROL_REGISTER_EN_HI:`MRS_WATCHDOG_CONTROL_REGISTER_EN_LO] != `MRS_WATCHDOG_CONTROL_REGISTER_ENA);

  // Under-voltage qualification; counter restarts on any glitch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lvq_q <= 24'h00_0000;
    end else if (!uv_s || sleep_mode) begin
      lvq_q <= 24'h00_0000;
    end else if (lvq_q != QUAL_CYC) begin
      lvq_q <= lvq_q + 24'h00_0001;
    end
  end

  // One pulse when the low level has lasted the full qualify time
  assign lvd_hit = uv_s && !sleep_mode &&
                   (lvq_q == QUAL_CYC - 24'h00_0001);

  assign full_req = lvd_hit || vsel_bad || watchdog_control_register_bad ||
                    (wdt_timeout && !sleep_mode && !idle_mode);
  assign wake_req = wdt_timeout && (sleep_mode || idle_mode);

  // Third slow tick: a full 2 to 3 slow cycles pass after the request
  assign activate = (state_q == mrs_pkg::MRS_ST_ARM) && slow_internal_oscillator_tick &&
                    (tick_q == `MRS_ACT_TICKS - 2'h1);

  always_comb begin
    unique case (osc_sel)
      mrs_pkg::MRS_OSC_HXT:  settle_cyc = `MRS_SST_HXT;
      mrs_pkg::MRS_OSC_SLOW_INTERNAL_OSCILLATOR: settle_cyc = `MRS_SST_SLOW_INTERNAL_OSCILLATOR;
      default:               settle_cyc = `MRS_SST_FAST_INTERNAL_OSCILLATOR;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q     <= mrs_pkg::MRS_ST_POR;
      cnt_q       <= 24'h00_0000;
      tick_q      <= 2'h0;
      wake_q      <= 1'b0;
      cause_lvd_q <= 1'b0;
    end else begin
      unique case (state_q)
        mrs_pkg::MRS_ST_POR: begin
          if (cnt_q == POD_CYC - 24'h00_0001) begin
            state_q <= mrs_pkg::MRS_ST_RUN;
            cnt_q   <= 24'h00_0000;
          end else begin
            cnt_q <= cnt_q + 24'h00_0001;
          end
        end
        mrs_pkg::MRS_ST_RUN: begin
          tick_q <= 2'h0;
          if (full_req) begin
            state_q     <= mrs_pkg::MRS_ST_ARM;
            wake_q      <= 1'b0;
            cause_lvd_q <= lvd_hit && !vsel_bad && !watchdog_control_register_bad;
          end else if (wake_req) begin
            state_q     <= mrs_pkg::MRS_ST_ARM;
            wake_q      <= 1'b1;
            cause_lvd_q <= 1'b0;
          end
        end
        mrs_pkg::MRS_ST_ARM: begin
          if (slow_internal_oscillator_tick) begin
            tick_q <= tick_q + 2'h1;
          end
          if (activate) begin
            state_q <= wake_q ? mrs_pkg::MRS_ST_SETTLE
                              : mrs_pkg::MRS_ST_HOLD;
            cnt_q   <= 24'h00_0000;
          end
        end
        mrs_pkg::MRS_ST_HOLD: begin
          if (cnt_q == POD_CYC - 24'h00_0001) begin
            state_q <= mrs_pkg::MRS_ST_RUN;
            cnt_q   <= 24'h00_0000;
          end else begin
            cnt_q <= cnt_q + 24'h00_0001;
          end
        end
        mrs_pkg::MRS_ST_SETTLE: begin
          if (cnt_q >= settle_cyc - 24'h00_0001) begin
            state_q <= mrs_pkg::MRS_ST_RUN;
            cnt_q   <= 24'h00_0000;
          end else begin
            cnt_q <= cnt_q + 24'h00_0001;
          end
        end
        default: begin
          state_q <= mrs_pkg::MRS_ST_POR;
          cnt_q   <= 24'h00_0000;
        end
      endcase
    end
  end

  // APB decode; zero wait states, read data captured in the setup phase
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `MRS_OFS_VSEL) || (paddr == `MRS_OFS_CTRL) ||
                   (paddr == `MRS_OFS_WATCHDOG_CONTROL_REGISTER) || (paddr == `MRS_OFS_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        `MRS_OFS_VSEL: prdata_q[7:0] <= vsel_q;
        `MRS_OFS_CTRL: begin
          prdata_q[`MRS_CTRL_KEEP] <= flags_q.idle_clock_keep;
          prdata_q[`MRS_CTRL_LV]   <= flags_q.low_voltage_flag;
          prdata_q[`MRS_CTRL_VSEL] <= flags_q.voltage_select_invalid_flag;
          prdata_q[`MRS_CTRL_WATCHDOG_CONTROL_REGISTER] <= flags_q.watchdog_ctrl_invalid_flag;
        end
        `MRS_OFS_WATCHDOG_CONTROL_REGISTER: prdata_q[7:0] <= watchdog_control_register_q;
        `MRS_OFS_STAT: begin
          prdata_q[`MRS_STAT_TO] <= stat_q.timeout_flag;
          prdata_q[`MRS_STAT_PD] <= stat_q.power_down_flag;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;

  // Threshold select register; invalid codes restored when reset fires
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vsel_q <= `MRS_VSEL_POR;
    end else if (activate && !wake_q && !cause_lvd_q) begin
      vsel_q <= `MRS_VSEL_POR;
    end else if (wr_en && paddr == `MRS_OFS_VSEL) begin
      vsel_q <= pwdata[7:0];
    end
  end

  // Watchdog control register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      watchdog_control_register_q <= `MRS_WATCHDOG_CONTROL_REGISTER_POR;
    end else if (activate && !wake_q && !cause_lvd_q) begin
      watchdog_control_register_q <= `MRS_WATCHDOG_CONTROL_REGISTER_POR;
    end else if (wr_en && paddr == `MRS_OFS_WATCHDOG_CONTROL_REGISTER) begin
      watchdog_control_register_q <= pwdata[7:0];
    end
  end

  // Cause flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
    end else begin
      if (wr_en && paddr == `MRS_OFS_CTRL) begin
        flags_q.idle_clock_keep <= pwdata[`MRS_CTRL_KEEP];
      end
      if (lvd_hit) begin
        flags_q.low_voltage_flag <= 1'b1;
      end else if (wr_en && paddr == `MRS_OFS_CTRL &&
                   !pwdata[`MRS_CTRL_LV]) begin
        flags_q.low_voltage_flag <= 1'b0;
      end
      if (vsel_bad) begin
        flags_q.voltage_select_invalid_flag <= 1'b1;
      end else if (wr_en && paddr == `MRS_OFS_CTRL &&
                   !pwdata[`MRS_CTRL_VSEL]) begin
        flags_q.voltage_select_invalid_flag <= 1'b0;
      end
      if (watchdog_control_register_bad) begin
        flags_q.watchdog_ctrl_invalid_flag <= 1'b1;
      end else if (wr_en && paddr == `MRS_OFS_CTRL &&
                   !pwdata[`MRS_CTRL_WATCHDOG_CONTROL_REGISTER]) begin
        flags_q.watchdog_ctrl_invalid_flag <= 1'b0;
      end
    end
  end

  // Timeout and power-down flags; only power-on clears them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stat_q <= '0;
    end else if (activate) begin
      stat_q.timeout_flag <= 1'b1;
      if (wake_q) begin
        stat_q.power_down_flag <= 1'b1;
      end
    end
  end

  // Port preset value held in a register for the port block
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port_q <= `MRS_PORT_INIT;
    end else begin
      port_q <= `MRS_PORT_INIT;
    end
  end

  // Outputs
  assign core_reset_n    = !(state_q == mrs_pkg::MRS_ST_POR ||
                             state_q == mrs_pkg::MRS_ST_HOLD);
  assign pc_sp_clear     = !core_reset_n ||
                           state_q == mrs_pkg::MRS_ST_SETTLE;
  assign port_preset     = !core_reset_n;
  assign port_init_value = port_q;
  assign watchdog_enable =
    watchdog_control_register_q[`MRS_WATCHDOG_CONTROL_REGISTER_EN_HI:`MRS_WATCHDOG_CONTROL_REGISTER_EN_LO] == `MRS_WATCHDOG_CONTROL_REGISTER_ENA;
  assign watchdog_period = watchdog_control_register_q[`MRS_WATCHDOG_CONTROL_REGISTER_WS_HI:0];
  assign idle_clock_keep = flags_q.idle_clock_keep;
  assign status          = stat_q;

endmodule : mrs_ctrl

`default_nettype wire

/* File: mrs_ctrl_checker.sv */
// Concurrent checks on the reset source controller ports.
// Assumes one clk_sys domain with resetn as the power-on reset.
`default_nettype none
`include "mrs_map.svh"

module mrs_ctrl_checker #(
  parameter logic [23:0] POD_CYC  = 24'h00_0014,
  parameter logic [23:0] QUAL_CYC = 24'h00_0005
) (
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 wdt_timeout,
  input wire logic                 sleep_mode,
  input wire logic                 idle_mode,
  input wire logic                 core_reset_n,
  input wire logic                 pc_sp_clear,
  input wire logic                 port_preset,
  input wire logic [7:0]           port_init_value,
  input wire mrs_pkg::mrs_status_t status
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [23:0] low_q;

  // Length of the current internal reset, zero while released
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) low_q <= 24'h00_0000;
    else if (core_reset_n) low_q <= 24'h00_0000;
    else low_q <= low_q + 24'h00_0001;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_wake_req;
    wdt_timeout && (sleep_mode || idle_mode) && core_reset_n && !pc_sp_clear;
  endsequence
  sequence s_full_req;
    wdt_timeout && !sleep_mode && !idle_mode && core_reset_n && !pc_sp_clear;
  endsequence

  pod_hold_a: assert property ($rose(core_reset_n) |->
    low_q + 24'h00_0001 >= POD_CYC && low_q <= POD_CYC + 24'h00_0001)
    else $error("internal reset length wrong");
  full_clear_a: assert property (!core_reset_n |->
    pc_sp_clear && port_preset) else $error("full reset outputs wrong");
  port_ones_a: assert property (port_init_value == 8'hFF)
    else $error("port preset value wrong");
  wdt_full_a: assert property (s_full_req |->
    ##[1:60] (!core_reset_n && status.timeout_flag))
    else $error("run time-out gave no reset");
  wdt_wake_a: assert property (s_wake_req |->
    ##[1:60] (pc_sp_clear && core_reset_n && status == 2'h3))
    else $error("wake time-out gave no settle");
  wake_keep_a: assert property (s_wake_req |=> core_reset_n [*8])
    else $error("wake time-out reset the core");
  flags_stick_a: assert property (!$fell(status.timeout_flag) &&
    !$fell(status.power_down_flag)) else $error("status flag dropped");
  ctrl_zero_a: assert property ($past(psel && !penable && !pwrite &&
    paddr == `MRS_OFS_CTRL) |-> prdata[6:3] == 4'h0)
    else $error("control bits 6 to 3 not zero");
  apb_answer_a: assert property (psel && penable |->
    pready && pslverr == (paddr > `MRS_OFS_STAT))
    else $error("bus answer wrong");
endmodule : mrs_ctrl_checker

bind mrs_ctrl mrs_ctrl_checker #(.POD_CYC(POD_CYC), .QUAL_CYC(QUAL_CYC)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wdt_timeout(wdt_timeout), .sleep_mode(sleep_mode),
  .idle_mode(idle_mode), .core_reset_n(core_reset_n),
  .pc_sp_clear(pc_sp_clear), .port_preset(port_preset),
  .port_init_value(port_init_value), .status(status));

`default_nettype wire

/* File: mrs_far_model.sv */
// Far side model: slow oscillator, supply detector and watchdog counter.
// Assumes the bench calls its tasks; oscillator runs free.
`default_nettype none

module mrs_far_model (
  input  wire logic clk_sys,
  output logic      slow_internal_oscillator,
  output logic      under_voltage,
  output logic      wdt_timeout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    slow_internal_oscillator = 1'b0;
    under_voltage = 1'b0;
    wdt_timeout = 1'b0;
  end

  // Period unrelated to clk_sys so tick phase varies
  always #43 slow_internal_oscillator = ~slow_internal_oscillator;

  task automatic uv_dip(input int n);
    @(posedge clk_sys);
    under_voltage <= 1'b1;
    repeat (n) @(posedge clk_sys);
    under_voltage <= 1'b0;
  endtask : uv_dip

  task automatic wdt_fire;
    @(posedge clk_sys);
    wdt_timeout <= 1'b1;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
  endtask : wdt_fire
endmodule : mrs_far_model

`default_nettype wire

/* File: mrs_ctrl_test.sv */
// Self-checking bench for the reset source controller.
// Assumes the far side model and the bound checker.
`default_nettype none
`include "mrs_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module mrs_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk_sys = 1'b0;
  logic                 resetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0000_0000;
  logic [31:0]          prdata;
  logic                 pready, pslverr, under_voltage, slow_osc, wdt_timeout;
  logic                 sleep_mode = 1'b0;
  logic                 idle_mode = 1'b0;
  mrs_pkg::mrs_osc_t    osc_sel = mrs_pkg::MRS_OSC_SLOW_INTERNAL_OSCILLATOR;
  logic                 core_reset_n, pc_sp_clear, port_preset;
  logic [7:0]           port_init_value;
  logic                 watchdog_enable, idle_clock_keep;
  logic [2:0]           watchdog_period;
  mrs_pkg::mrs_status_t status;
  int                   n_mismatch = 0;
  int                   samples_checked = 0;
  int                   n;

  always #5 clk_sys = ~clk_sys;

  mrs_ctrl #(.POD_CYC(24'h00_0014), .QUAL_CYC(24'h00_0005)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .under_voltage(under_voltage),
    .slow_internal_oscillator(slow_osc), .wdt_timeout(wdt_timeout),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .osc_sel(osc_sel),
    .core_reset_n(core_reset_n), .pc_sp_clear(pc_sp_clear),
    .port_preset(port_preset), .port_init_value(port_init_value),
    .watchdog_enable(watchdog_enable), .watchdog_period(watchdog_period),
    .idle_clock_keep(idle_clock_keep), .status(status));

  mrs_far_model u_far (.clk_sys(clk_sys), .slow_internal_oscillator(slow_osc),
    .under_voltage(under_voltage), .wdt_timeout(wdt_timeout));

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h00_0000, d}, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r, {24'h00_0000, x})
  endtask : rd

  // Cycles of internal reset (sel 0) or of wake settle (sel 1)
  task automatic span(input int sel, output int c);
    int k;
    c = 0;
    k = 0;
    while ((sel ? pc_sp_clear : !core_reset_n) !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    while ((sel ? pc_sp_clear : !core_reset_n) === 1'b1 && c < 2000) begin
      @(posedge clk_sys);
      c++;
    end
  endtask : span

  // Counts every cycle of reset, not only the last one
  task automatic quiet;
    int lows;
    lows = 0;
    repeat (80) begin
      @(posedge clk_sys);
      if (core_reset_n !== 1'b1) lows++;
    end
    `CHK(lows, 0)
  endtask : quiet

  task automatic t_por;
    logic [31:0] r;
    logic e;
    resetn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    span(0, n);
    `CHK(n >= 19 && n <= 21, 1'b1)
    rd(`MRS_OFS_VSEL, 8'h55);
    rd(`MRS_OFS_CTRL, 8'h00);
    rd(`MRS_OFS_WATCHDOG_CONTROL_REGISTER, 8'h53);
    rd(`MRS_OFS_STAT, 8'h00);
    apb(1'b0, 12'h010, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    `CHK({port_init_value, watchdog_enable, watchdog_period}, 12'hFFB)
    $display("done t_por");
  endtask : t_por

  task automatic t_codes;
    logic [7:0] c [4] = '{8'h55, 8'h99, 8'hAA, 8'h33};
    foreach (c[i]) begin
      wr(`MRS_OFS_VSEL, c[i]);
      rd(`MRS_OFS_VSEL, c[i]);
    end
    wr(`MRS_OFS_CTRL, 8'hFF);
    rd(`MRS_OFS_CTRL, 8'h80);
    `CHK(idle_clock_keep, 1'b1)
    wr(`MRS_OFS_CTRL, 8'h00);
    quiet();
    $display("done t_codes");
  endtask : t_codes

  task automatic t_uv;
    u_far.uv_dip(3);
    quiet();
    sleep_mode <= 1'b1;
    u_far.uv_dip(20);
    quiet();
    sleep_mode <= 1'b0;
    rd(`MRS_OFS_CTRL, 8'h00);
    fork
      u_far.uv_dip(20);
      span(0, n);
    join
    `CHK(n >= 19 && n <= 21, 1'b1)
    rd(`MRS_OFS_CTRL, 8'h04);
    rd(`MRS_OFS_VSEL, 8'h33);
    wr(`MRS_OFS_CTRL, 8'h00);
    rd(`MRS_OFS_CTRL, 8'h00);
    $display("done t_uv");
  endtask : t_uv

  task automatic t_bad_codes;
    wr(`MRS_OFS_VSEL, 8'h00);
    span(0, n);
    `CHK(n >= 19 && n <= 21, 1'b1)
    rd(`MRS_OFS_CTRL, 8'h02);
    rd(`MRS_OFS_VSEL, 8'h55);
    wr(`MRS_OFS_CTRL, 8'h00);
    wr(`MRS_OFS_WATCHDOG_CONTROL_REGISTER, 8'hAF);
    quiet();
    `CHK({watchdog_enable, watchdog_period}, 4'h7)
    wr(`MRS_OFS_WATCHDOG_CONTROL_REGISTER, 8'h07);
    span(0, n);
    `CHK(n >= 19 && n <= 21, 1'b1)
    rd(`MRS_OFS_CTRL, 8'h01);
    rd(`MRS_OFS_WATCHDOG_CONTROL_REGISTER, 8'h53);
    wr(`MRS_OFS_CTRL, 8'h00);
    $display("done t_bad_codes");
  endtask : t_bad_codes

  task automatic t_wdt;
    mrs_pkg::mrs_osc_t o [3] = '{mrs_pkg::MRS_OSC_FAST_INTERNAL_OSCILLATOR, mrs_pkg::MRS_OSC_HXT,
                                 mrs_pkg::MRS_OSC_SLOW_INTERNAL_OSCILLATOR};
    int s [3] = '{16, 1024, 2};
    fork
      u_far.wdt_fire();
      span(0, n);
    join
    `CHK(n >= 19 && n <= 21, 1'b1)
    `CHK(status, 2'h2)
    wr(`MRS_OFS_VSEL, 8'h99);
    foreach (o[i]) begin
      osc_sel <= o[i];
      sleep_mode <= (i != 1);
      idle_mode <= (i == 1);
      fork
        u_far.wdt_fire();
        span(1, n);
      join
      `CHK(n >= s[i] - 1 && n <= s[i] + 1, 1'b1)
      `CHK(core_reset_n, 1'b1)
      `CHK(status, 2'h3)
    end
    sleep_mode <= 1'b0;
    idle_mode <= 1'b0;
    rd(`MRS_OFS_VSEL, 8'h99);
    $display("done t_wdt");
  endtask : t_wdt

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    t_por();
    t_codes();
    t_uv();
    t_bad_codes();
    t_wdt();
    t_por();
    give_verdict();
  end

  initial begin
    #400us;
    n_mismatch++;
    give_verdict();
  end
endmodule : mrs_ctrl_test

`default_nettype wire
